/* File: logic/charger_threshold_settings.sv */
// charger threshold settings: two byte registers and their setpoints
// assumes a serial front end turns host transfers into one-cycle
// read and write strobes with an address, all on CLK_I
`timescale 1ns/1ps

module charger_threshold_settings
  import charger_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input  wire logic                 CLK_I,
  input  wire logic                 RST_B_I,
  // register access port
  input  wire logic [ADDR_W-1:0]    ADDR_I,
  input  wire logic                 WR_I,
  input  wire logic [7:0]           WDATA_I,
  input  wire logic                 RD_I,
  output logic      [7:0]           RDATA_O,
  output logic                      RVALID_O,
  // stored codes
  output logic      [FAST_W-1:0]    FAST_CODE_O,
  output logic      [TRK_W-1:0]     TRK_CODE_O,
  output logic      [HYST_W-1:0]    HYST_CODE_O,
  output logic      [DEAD_W-1:0]    DEAD_CODE_O,
  output logic      [WEAK_W-1:0]    WEAK_CODE_O,
  // decoded setpoints for the charger loop
  output logic      [CUR_MA_W-1:0]  FAST_MA_O,
  output logic      [TRK_MA_W-1:0]  TRK_MA_O,
  output logic      [HYST_MV_W-1:0] HYST_MV_O,
  output logic      [THR_MV_W-1:0]  DEAD_MV_O,
  output logic      [THR_MV_W-1:0]  WEAK_MV_O
);

  // the address decode compares against 8-bit register addresses
  if (ADDR_W < 8 || ADDR_W > 16) begin : g_bad_addr
    $error("ADDR_W must lie between 8 and 16");
  end

  logic [FAST_W-1:0]    fast_code, next_fast_code;
  logic [TRK_W-1:0]     trk_code,  next_trk_code;
  logic [HYST_W-1:0]    hyst_code, next_hyst_code;
  logic [DEAD_W-1:0]    dead_code, next_dead_code;
  logic [WEAK_W-1:0]    weak_code, next_weak_code;
  logic [7:0]           rdata,     next_rdata;
  logic                 rvalid,    next_rvalid;
  logic                 cur_sel, volt_sel;
  logic [CUR_MA_W-1:0]  fast_ma;
  logic [TRK_MA_W-1:0]  trk_ma;
  logic [HYST_MV_W-1:0] hyst_mv;
  logic [THR_MV_W-1:0]  dead_mv, weak_mv;
  logic [CUR_MA_W-1:0]  fast_ma_q;
  logic [TRK_MA_W-1:0]  trk_ma_q;
  logic [HYST_MV_W-1:0] hyst_mv_q;
  logic [THR_MV_W-1:0]  dead_mv_q, weak_mv_q;

  // address decode; upper address bits must be zero
  always_comb begin
    cur_sel  = 1'b0;
    volt_sel = 1'b0;
    if (ADDR_I == ADDR_W'(CUR_SET_ADDR)) begin
      cur_sel = 1'b1;
    end else if (ADDR_I == ADDR_W'(VOLT_THR_ADDR)) begin
      volt_sel = 1'b1;
    end
  end

  // next register state; writes to other addresses are dropped
  always_comb begin
    next_fast_code = fast_code;
    next_trk_code  = trk_code;
    next_hyst_code = hyst_code;
    next_dead_code = dead_code;
    next_weak_code = weak_code;
    if (WR_I && cur_sel) begin
      next_fast_code = WDATA_I[FAST_LSB +: FAST_W];
      next_trk_code  = WDATA_I[TRK_LSB +: TRK_W];
    end
    if (WR_I && volt_sel) begin
      next_hyst_code = WDATA_I[HYST_LSB +: HYST_W];
      next_dead_code = WDATA_I[DEAD_LSB +: DEAD_W];
      next_weak_code = WDATA_I[WEAK_LSB +: WEAK_W];
    end
  end

  // read path: end-of-charge bits live elsewhere, so 7:6 of the current register and 7 of the voltage register read zero
  always_comb begin
    next_rvalid = RD_I;
    next_rdata  = rdata;
    if (RD_I) begin
      next_rdata = 8'h00;
      if (cur_sel) begin
        next_rdata[FAST_LSB +: FAST_W] = fast_code;
        next_rdata[TRK_LSB +: TRK_W]   = trk_code;
      end else if (volt_sel) begin
        next_rdata[HYST_LSB +: HYST_W] = hyst_code;
        next_rdata[DEAD_LSB +: DEAD_W] = dead_code;
        next_rdata[WEAK_LSB +: WEAK_W] = weak_code;
      end
    end
  end

  // register state
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fast_code <= FAST_RST;
      trk_code  <= TRK_RST;
      hyst_code <= HYST_RST;
      dead_code <= DEAD_RST;
      weak_code <= WEAK_RST;
      rdata     <= 8'h00;
      rvalid    <= 1'b0;
    end else begin
      fast_code <= next_fast_code;
      trk_code  <= next_trk_code;
      hyst_code <= next_hyst_code;
      dead_code <= next_dead_code;
      weak_code <= next_weak_code;
      rdata     <= next_rdata;
      rvalid    <= next_rvalid;
    end
  end

  setpoint_decode u_decode (
    .fast_i    (fast_code),
    .trk_i     (trk_code),
    .hyst_i    (hyst_code),
    .dead_i    (dead_code),
    .weak_i    (weak_code),
    .fast_ma_o (fast_ma),
    .trk_ma_o  (trk_ma),
    .hyst_mv_o (hyst_mv),
    .dead_mv_o (dead_mv),
    .weak_mv_o (weak_mv)
  );

  // setpoints registered: costs a cycle, keeps analog inputs glitch free
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fast_ma_q <= '0;
      trk_ma_q  <= '0;
      hyst_mv_q <= '0;
      dead_mv_q <= '0;
      weak_mv_q <= '0;
    end else begin
      fast_ma_q <= fast_ma;
      trk_ma_q  <= trk_ma;
      hyst_mv_q <= hyst_mv;
      dead_mv_q <= dead_mv;
      weak_mv_q <= weak_mv;
    end
  end

  // outputs
  assign RDATA_O     = rdata;
  assign RVALID_O    = rvalid;
  assign FAST_CODE_O = fast_code;
  assign TRK_CODE_O  = trk_code;
  assign HYST_CODE_O = hyst_code;
  assign DEAD_CODE_O = dead_code;
  assign WEAK_CODE_O = weak_code;
  assign FAST_MA_O   = fast_ma_q;
  assign TRK_MA_O    = trk_ma_q;
  assign HYST_MV_O   = hyst_mv_q;
  assign DEAD_MV_O   = dead_mv_q;
  assign WEAK_MV_O   = weak_mv_q;

  // helper for checking reset values: low only in the first cycle
  logic booted;
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      booted <= 1'b0;
    end else begin
      booted <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  reset_codes_a: assert property (
    !booted |-> FAST_CODE_O == 4'hc && TRK_CODE_O == 2'h2 &&
      HYST_CODE_O == 2'h3 && DEAD_CODE_O == 2'h1 && WEAK_CODE_O == 3'h3)
    else $error("codes not at reset values");

  // setpoint lags the code by one edge, so compare with the code a cycle back
  fast_decode_a: assert property (
    WR_I && cur_sel |=> ##1 FAST_MA_O == (($past(FAST_CODE_O) < 4'h6) ?
      10'(25 * ($past(FAST_CODE_O) + 1)) :
      10'(200 + 50 * ($past(FAST_CODE_O) - 6))))
    else $error("fast current setpoint wrong");

  trickle_write_a: assert property (
    WR_I && cur_sel && WDATA_I[1:0] == 2'h3 |=> TRK_CODE_O == 2'h3
      ##1 TRK_MA_O == 6'h32)
    else $error("trickle code or setpoint wrong");

  hyst_write_a: assert property (
    WR_I && volt_sel |=> HYST_CODE_O == $past(WDATA_I[6:5])
      ##1 HYST_MV_O == 9'(80 + 60 * $past(HYST_CODE_O)))
    else $error("hysteresis code or setpoint wrong");

  dead_write_a: assert property (
    WR_I && volt_sel && WDATA_I[4:3] == 2'h3 |=> DEAD_CODE_O == 2'h3
      ##1 DEAD_MV_O == 12'hce4)
    else $error("dead battery setpoint wrong");

  weak_write_a: assert property (
    WR_I && volt_sel |=> WEAK_CODE_O == $past(WDATA_I[2:0])
      ##1 WEAK_MV_O == 12'(2700 + 100 * $past(WEAK_CODE_O)))
    else $error("weak battery code or setpoint wrong");

  fast_write_a: assert property (
    WR_I && cur_sel |=> FAST_CODE_O == $past(WDATA_I[5:2]))
    else $error("fast code not stored");

  codes_hold_a: assert property (
    !(WR_I && (cur_sel || volt_sel)) |=> $stable(FAST_CODE_O) &&
      $stable(TRK_CODE_O) && $stable(HYST_CODE_O) &&
      $stable(DEAD_CODE_O) && $stable(WEAK_CODE_O))
    else $error("code changed without a write");

  read_back_a: assert property (
    RD_I && cur_sel && !WR_I |=> RVALID_O && RDATA_O[7:6] == 2'h0 &&
      RDATA_O[5:2] == FAST_CODE_O && RDATA_O[1:0] == TRK_CODE_O)
    else $error("current register read back wrong");

  cur_write_c:  cover property (WR_I && cur_sel ##2 FAST_MA_O == 10'h28a);
  wr_rd_c:      cover property (WR_I && RD_I && cur_sel ##1 RD_I && volt_sel);
  unmapped_c:   cover property (WR_I && !cur_sel && !volt_sel);

endmodule : charger_threshold_settings

/* File: common/charger_pkg.sv */
// constants for the charger threshold settings register bank
// assumes one system clock and a byte-wide register access port
package charger_pkg;

  // register addresses
  localparam logic [7:0] CUR_SET_ADDR  = 8'h04;
  localparam logic [7:0] VOLT_THR_ADDR = 8'h05;

  // field positions and widths
  localparam int FAST_LSB = 2;
  localparam int FAST_W   = 4;
  localparam int TRK_LSB  = 0;
  localparam int TRK_W    = 2;
  localparam int HYST_LSB = 5;
  localparam int HYST_W   = 2;
  localparam int DEAD_LSB = 3;
  localparam int DEAD_W   = 2;
  localparam int WEAK_LSB = 0;
  localparam int WEAK_W   = 3;

  // values after reset
  localparam logic [3:0] FAST_RST = 4'hc;
  localparam logic [1:0] TRK_RST  = 2'h2;
  localparam logic [1:0] HYST_RST = 2'h3;
  localparam logic [1:0] DEAD_RST = 2'h1;
  localparam logic [2:0] WEAK_RST = 3'h3;

  // setpoint widths: current in mA, voltages in mV
  localparam int CUR_MA_W  = 10;
  localparam int TRK_MA_W  = 6;
  localparam int HYST_MV_W = 9;
  localparam int THR_MV_W  = 12;

  // fast current decode: fine steps below the knee, coarse above
  localparam logic [3:0]          FAST_KNEE    = 4'h6;
  localparam logic [CUR_MA_W-1:0] FAST_LO_STEP = 10'h019; // 25 mA
  localparam logic [CUR_MA_W-1:0] FAST_HI_BASE = 10'h0c8; // 200 mA
  localparam logic [CUR_MA_W-1:0] FAST_HI_STEP = 10'h032; // 50 mA

  // trickle current table, 5/10/20/50 mA
  localparam logic [TRK_MA_W-1:0] TRK_MA_0 = 6'h05;
  localparam logic [TRK_MA_W-1:0] TRK_MA_1 = 6'h0a;
  localparam logic [TRK_MA_W-1:0] TRK_MA_2 = 6'h14;
  localparam logic [TRK_MA_W-1:0] TRK_MA_3 = 6'h32;

  // recharge hysteresis, 80 mV plus 60 mV per code
  localparam logic [HYST_MV_W-1:0] HYST_BASE = 9'h050;
  localparam logic [HYST_MV_W-1:0] HYST_STEP = 9'h03c;

  // dead battery threshold table, 2.4/2.5/2.6/3.3 V
  localparam logic [THR_MV_W-1:0] DEAD_MV_0 = 12'h960;
  localparam logic [THR_MV_W-1:0] DEAD_MV_1 = 12'h9c4;
  localparam logic [THR_MV_W-1:0] DEAD_MV_2 = 12'ha28;
  localparam logic [THR_MV_W-1:0] DEAD_MV_3 = 12'hce4;

  // weak battery rising threshold, 2.7 V plus 0.1 V per code
  localparam logic [THR_MV_W-1:0] WEAK_BASE = 12'ha8c;
  localparam logic [THR_MV_W-1:0] WEAK_STEP = 12'h064;

endpackage : charger_pkg

/* File: logic/setpoint_decode.sv */
// combinational decode of stored codes into analog setpoints
// assumes the caller registers the results before they leave the block
`timescale 1ns/1ps
module setpoint_decode
  import charger_pkg::*;
(
  // stored codes
  input  wire logic [FAST_W-1:0]    fast_i,
  input  wire logic [TRK_W-1:0]     trk_i,
  input  wire logic [HYST_W-1:0]    hyst_i,
  input  wire logic [DEAD_W-1:0]    dead_i,
  input  wire logic [WEAK_W-1:0]    weak_i,
  // decoded setpoints
  output logic      [CUR_MA_W-1:0]  fast_ma_o,
  output logic      [TRK_MA_W-1:0]  trk_ma_o,
  output logic      [HYST_MV_W-1:0] hyst_mv_o,
  output logic      [THR_MV_W-1:0]  dead_mv_o,
  output logic      [THR_MV_W-1:0]  weak_mv_o
);

  logic [CUR_MA_W-1:0] fast_wide;

  // fast current: two linear segments split at the knee, 150 mA just below it and 200 mA at it
  always_comb begin
    fast_wide = {{(CUR_MA_W-FAST_W){1'b0}}, fast_i};
    if (fast_i < FAST_KNEE) begin
      fast_ma_o = CUR_MA_W'(FAST_LO_STEP * (fast_wide + 10'h001));
    end else begin
      fast_ma_o = CUR_MA_W'(FAST_HI_BASE + FAST_HI_STEP *
                  (fast_wide - {6'h00, FAST_KNEE}));
    end
  end

  // table lookups, not linear
  always_comb begin
    case (trk_i)
      2'h0:    trk_ma_o = TRK_MA_0;
      2'h1:    trk_ma_o = TRK_MA_1;
      2'h2:    trk_ma_o = TRK_MA_2;
      default: trk_ma_o = TRK_MA_3;
    endcase
    case (dead_i)
      2'h0:    dead_mv_o = DEAD_MV_0;
      2'h1:    dead_mv_o = DEAD_MV_1;
      2'h2:    dead_mv_o = DEAD_MV_2;
      default: dead_mv_o = DEAD_MV_3;
    endcase
  end

  // linear voltage setpoints
  assign hyst_mv_o = HYST_MV_W'(HYST_BASE + HYST_STEP *
                     {{(HYST_MV_W-HYST_W){1'b0}}, hyst_i});
  assign weak_mv_o = THR_MV_W'(WEAK_BASE + WEAK_STEP *
                     {{(THR_MV_W-WEAK_W){1'b0}}, weak_i});

endmodule : setpoint_decode

/* File: bench/charger_threshold_settings_tb_top.sv */
// bench for the charger threshold settings register bank
// assumes the strobe port of the notes; inputs driven on falling edges
`timescale 1ns/1ps
module charger_threshold_settings_tb_top;
  import charger_pkg::*;
  logic clk, rst_b, wr, rd, rvalid;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] f_o; logic [1:0] t_o, h_o, d_o; logic [2:0] w_o;
  logic [9:0] fma; logic [5:0] tma; logic [8:0] hmv;
  logic [11:0] dmv, wmv;
  // expected codes, kept by the bench alone
  logic [3:0] cf; logic [1:0] ct, ch, cd; logic [2:0] cw;
  int n_fail = 0, compares = 0, cycles = 0;

  charger_threshold_settings dut (
    .CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WR_I(wr),
    .WDATA_I(wdata), .RD_I(rd), .RDATA_O(rdata), .RVALID_O(rvalid),
    .FAST_CODE_O(f_o), .TRK_CODE_O(t_o), .HYST_CODE_O(h_o),
    .DEAD_CODE_O(d_o), .WEAK_CODE_O(w_o), .FAST_MA_O(fma),
    .TRK_MA_O(tma), .HYST_MV_O(hmv), .DEAD_MV_O(dmv), .WEAK_MV_O(wmv));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard, well above the 765 or so cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask : chk

  task automatic chk_rd(input logic [7:0] exp);
    chk({11'h000, rvalid}, 12'h001, "read valid");
    chk({4'h0, rdata}, {4'h0, exp}, "read data");
  endtask : chk_rd

  // decodes worked out from the setpoint tables
  function automatic logic [11:0] fast_ma(input logic [3:0] c);
    int v;
    v = c;
    return (v < 6) ? 12'(25 * (v + 1)) : 12'(200 + 50 * (v - 6));
  endfunction : fast_ma

  function automatic logic [11:0] trk_ma(input logic [1:0] c);
    case (c)
      2'h0: return 12'h005;
      2'h1: return 12'h00a;
      2'h2: return 12'h014;
      default: return 12'h032;
    endcase
  endfunction : trk_ma

  function automatic logic [11:0] dead_mv(input logic [1:0] c);
    case (c)
      2'h0: return 12'(2400);
      2'h1: return 12'(2500);
      2'h2: return 12'(2600);
      default: return 12'(3300);
    endcase
  endfunction : dead_mv

  task automatic chk_codes();
    chk({8'h00, f_o}, {8'h00, cf}, "fast code");
    chk({10'h000, t_o}, {10'h000, ct}, "trickle code");
    chk({10'h000, h_o}, {10'h000, ch}, "hyst code");
    chk({10'h000, d_o}, {10'h000, cd}, "dead code");
    chk({9'h000, w_o}, {9'h000, cw}, "weak code");
  endtask : chk_codes

  task automatic chk_sp();
    chk({2'h0, fma}, fast_ma(cf), "fast mA");
    chk({6'h00, tma}, trk_ma(ct), "trickle mA");
    chk({3'h0, hmv}, 12'(80 + 60 * int'(ch)), "hyst mV");
    chk(dmv, dead_mv(cd), "dead mV");
    chk(wmv, 12'(2700 + 100 * int'(cw)), "weak mV");
  endtask : chk_sp

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk_rd(exp);
  endtask : rd_reg

  task automatic set_rst_vals();
    cf = 4'hc; ct = 2'h2; ch = 2'h3; cd = 2'h1; cw = 3'h3;
  endtask : set_rst_vals

  // main sequence
  initial begin
    rst_b = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    set_rst_vals();
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk_codes();
    chk_sp();
    rd_reg(CUR_SET_ADDR, 8'h32);
    rd_reg(VOLT_THR_ADDR, 8'h6b);
    $display("test reset values done");
    // every fast and trickle code, top bits written high but dropped
    for (int i = 0; i < 16; i++) begin
      cf = 4'(i); ct = 2'(i);
      wr_reg(CUR_SET_ADDR, {2'h3, cf, ct});
      chk_codes();
      @(negedge clk);
      chk_sp();
      rd_reg(CUR_SET_ADDR, {2'h0, cf, ct});
    end
    $display("test current register done");
    // every voltage threshold combination, bit 7 written high
    for (int i = 0; i < 128; i++) begin
      {ch, cd, cw} = 7'(i);
      wr_reg(VOLT_THR_ADDR, {1'b1, ch, cd, cw});
      chk_codes();
      @(negedge clk);
      chk_sp();
      rd_reg(VOLT_THR_ADDR, {1'b0, ch, cd, cw});
    end
    $display("test voltage register done");
    // unmapped places leave the settings alone and read zero
    wr_reg(8'h06, 8'h00);
    wr_reg(8'h03, 8'h00);
    repeat (20) @(negedge clk);
    chk_codes();
    chk_sp();
    rd_reg(8'h06, 8'h00);
    $display("test unmapped and hold done");
    // write and read together: old value back, then new one
    @(negedge clk);
    addr = CUR_SET_ADDR; wdata = 8'h05; wr = 1'b1; rd = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = VOLT_THR_ADDR;
    chk_rd({2'h0, cf, ct});
    cf = 4'h1; ct = 2'h1;
    @(negedge clk);
    rd = 1'b0;
    chk_rd({1'b0, ch, cd, cw});
    chk_codes();
    rd_reg(CUR_SET_ADDR, 8'h05);
    $display("test simultaneous and back to back done");
    // reset in mid run restores every code
    @(negedge clk);
    rst_b = 1'b0;
    set_rst_vals();
    @(negedge clk);
    chk_codes();
    chk({2'h0, fma}, 12'h000, "fast mA in reset");
    rst_b = 1'b1;
    @(negedge clk);
    chk_sp();
    $display("test second reset done");
    results();
  end
endmodule : charger_threshold_settings_tb_top
